/* bench/cmb_core_model.sv */
// protocol core stand-in: sends whatever transmit the block offers after a set lag
// assumes tx_frame is stable while tx_pending is high; lag of at least 2 cycles
`timescale 1ns/1ps
`default_nettype none
module cmb_core_model (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   resetn,
	// transmit side of the block
	input  wire logic                   tx_pending,
	input  wire cmb_pkg::cmb_tx_frame_t tx_frame,
	input  wire logic [3:0]             lag,
	output logic                        tx_done,
	output logic [4:0]                  tx_done_obj
);
	import cmb_pkg::*;
	cmb_tx_frame_t sent;
	int            n_sent;
	logic [3:0]    cnt;
	initial begin
		tx_done = 1'b0;
		tx_done_obj = 5'h00;
		sent = '0;
		n_sent = 0;
		cnt = 4'h0;
	end
	////////////////////////////////////////
	always @(posedge clk) begin
		#1;
		tx_done <= 1'b0;
		// index line is inverted every cycle between sends, so a stale index cannot pass for valid
		tx_done_obj <= ~tx_done_obj;
		if (!resetn || !tx_pending) begin
			cnt <= 4'h0;
		end else if (cnt < lag) begin
			cnt <= cnt + 4'h1;
		end else begin
			tx_done <= 1'b1;
			tx_done_obj <= tx_frame.obj;
			sent <= tx_frame;
			n_sent <= n_sent + 1;
			cnt <= 4'h0;
		end
	end
endmodule : cmb_core_model
`default_nettype wire

/* bench/cmb_msg_buffer_sva.sv */
// port assertions for the message buffer block: transfer busy window, readback, interrupt pin
// assumes one clock domain and the active-low asynchronous reset of the block
`timescale 1ns/1ps
`default_nettype none
module cmb_msg_buffer_sva (
	// clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// register port
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        host_wait_n,
	// core events and interrupt
	input wire logic        rx_valid,
	input wire logic        rx_hit,
	input wire logic        status_update,
	input wire logic        status_read,
	input wire logic        irq_output_enable,
	input wire logic        irq_polarity_select,
	input wire logic [15:0] irq_source_identifier,
	input wire logic        irq_output_pin
);
	import cmb_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////
	// a request on set one taken while both sets idle
	sequence s_req1;
		reg_wr && reg_addr == IFACE1_BASE && host_wait_n;
	endsequence
	// wait stays low for the whole transfer, then lets go
	sequence s_wait4;
		!host_wait_n [*4] ##1 host_wait_n;
	endsequence
	sequence s_busy_rd;
		reg_rd && reg_addr == IFACE1_BASE + 8'h01;
	endsequence
	a_busy_window: assert property (s_req1 |=> s_wait4)
		else $error("wait window after transfer request is wrong");
	a_busy_readback: assert property (s_req1 ##1 s_busy_rd |=> reg_rdata == 8'h80)
		else $error("busy flag not set right after request");
	a_idle_busy: assert property (reg_rd && reg_addr == IFACE2_BASE + 8'h01 && host_wait_n
		|=> reg_rdata == 8'h00)
		else $error("busy flag set while idle");
	a_mask_spare: assert property (reg_rd && (reg_addr == IFACE1_BASE + 8'h06 || reg_addr == IFACE2_BASE + 8'h06)
		|=> reg_rdata[5])
		else $error("spare mask bit reads zero");
	a_rx_hit_cause: assert property (rx_hit |-> $past(rx_valid))
		else $error("frame taken without an offered frame");
	a_status_id: assert property (status_update |-> ##[1:2] irq_source_identifier == STATUS_IRQ_ID)
		else $error("status update not shown in identifier");
	a_status_clear: assert property (irq_source_identifier == STATUS_IRQ_ID && status_read && !status_update
		|-> ##[1:2] irq_source_identifier != STATUS_IRQ_ID)
		else $error("status read did not clear status interrupt");
	a_pin_level: assert property (1'b1 |=> irq_output_pin ==
		(($past(irq_source_identifier) != IRQ_ID_NONE && $past(irq_output_enable))
		? $past(irq_polarity_select) : !$past(irq_polarity_select)))
		else $error("interrupt pin level wrong");
	a_id_legal: assert property (irq_source_identifier == STATUS_IRQ_ID || irq_source_identifier <= 16'h0020)
		else $error("identifier outside legal codes");
endmodule : cmb_msg_buffer_sva
bind cmb_msg_buffer cmb_msg_buffer_sva i_sva (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_wait_n(host_wait_n),
	.rx_valid(rx_valid), .rx_hit(rx_hit), .status_update(status_update), .status_read(status_read),
	.irq_output_enable(irq_output_enable), .irq_polarity_select(irq_polarity_select),
	.irq_source_identifier(irq_source_identifier), .irq_output_pin(irq_output_pin));
`default_nettype wire

/* bench/cmb_msg_buffer_tb_top.sv */
// bench top: buffer transfers, received frames, transmits, interrupt identifier and pin
// assumes cmb_core_model on the transmit side and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module cmb_msg_buffer_tb_top;
	import cmb_pkg::*;
	logic          clk, resetn, reg_wr, reg_rd, rx_valid, tx_pending, tx_done, rx_hit, host_wait_n;
	logic          status_update, status_read, irq_output_enable, irq_polarity_select, irq_output_pin;
	logic [7:0]    reg_addr, reg_wdata, reg_rdata;
	logic [4:0]    tx_done_obj;
	logic [3:0]    lag;
	logic [15:0]   irq_source_identifier;
	logic [31:0]   seed;
	logic [63:0]   got;
	logic [7:0]    b [18];
	logic [7:0]    q [18];
	logic [28:0]   oid [33];
	logic [5:0]    nums [3];
	cmb_rx_frame_t rx_frame;
	cmb_tx_frame_t tx_frame;
	int            err_count, check_count, cycles;
	cmb_msg_buffer i_dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .host_wait_n,
		.rx_valid, .rx_frame, .rx_hit, .tx_pending, .tx_frame, .tx_done, .tx_done_obj, .status_update,
		.status_read, .irq_output_enable, .irq_polarity_select, .irq_source_identifier, .irq_output_pin);
	cmb_core_model i_core (.clk, .resetn, .tx_pending, .tx_frame, .lag, .tx_done, .tx_done_obj);
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			$display("unexpected at %0t: run did not finish", $time);
			wrap_up();
		end
	end
	////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [5:0] fold(input logic [5:0] n);
		return (n == 6'h00) ? 6'h20 : (n > 6'h20) ? n - 6'h20 : n;
	endfunction : fold
	function automatic logic pin_exp(input logic pend, input logic en, input logic pol);
		return (pend && en) ? pol : !pol;
	endfunction : pin_exp
	// inputs move 2 ns after the edge so the design never races the bench
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : tick
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		tick(1);
		reg_wr = 1'b0;
		tick(1);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		reg_addr = a;
		reg_rd = 1'b1;
		tick(1);
		reg_rd = 1'b0;
		tick(1);
	endtask : rd
	task automatic xfer(input logic [7:0] base, input logic [5:0] num, input logic dir);
		int n;
		wr(base + 8'h02, {dir, 7'h00});
		reg_addr = base;
		reg_wdata = {2'b00, num};
		reg_wr = 1'b1;
		tick(1);
		reg_wr = 1'b0;
		reg_addr = base + 8'h01;
		reg_rd = 1'b1;
		tick(1);
		reg_rd = 1'b0;
		chk(64'(reg_rdata), 64'h80);
		n = 2;
		while (!host_wait_n && n < 20) begin
			tick(1);
			n++;
		end
		chk(64'(n), 64'(XFER_CYCLES) + 64'd1);
	endtask : xfer
	task automatic put(input logic [7:0] base, input logic [5:0] num);
		for (int i = 0; i < 18; i++) wr(base + 8'h03 + 8'(i), b[i]);
		xfer(base, num, 1'b1);
	endtask : put
	task automatic get(input logic [7:0] base, input logic [5:0] num);
		xfer(base, num, 1'b0);
		for (int i = 0; i < 18; i++) begin
			rd(base + 8'h03 + 8'(i));
			q[i] = reg_rdata;
		end
	endtask : get
	// random object image: full compare mask, single-object end marker
	task automatic mk(input logic [28:0] id, input logic [2:0] vxd, input logic [7:0] ch);
		for (int i = 0; i < 18; i++) begin
			seed = lfsr(seed);
			b[i] = seed[7:0];
		end
		{b[3], b[2], b[1], b[0]} = 32'hFFFFFFFF;
		{b[7], b[6], b[5], b[4]} = {vxd, id};
		b[8] = {4'h8, b[8][3:0]};
		b[9] = ch;
	endtask : mk
	task automatic rx(input logic [28:0] id, input logic xtd, input logic rem, input logic hit);
		seed = lfsr(seed);
		rx_frame = {id, xtd, rem, seed[3:0], seed, lfsr(seed)};
		rx_valid = 1'b1;
		tick(1);
		rx_valid = 1'b0;
		chk(64'(rx_hit), 64'(hit));
		tick(1);
	endtask : rx
	task automatic tx_chk(input int n0, input logic [4:0] obj, input logic rem);
		int t;
		t = 0;
		while (i_core.n_sent == n0 && t < 200) begin
			tick(1);
			t++;
		end
		chk(64'(i_core.sent.obj), 64'(obj));
		chk(64'(i_core.sent.remote), 64'(rem));
		if (!rem) chk(i_core.sent.data, {b[17], b[16], b[15], b[14], b[13], b[12], b[11], b[10]});
	endtask : tx_chk
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		{reg_wr, reg_rd, rx_valid, status_update, status_read, irq_output_enable, irq_polarity_select} = 7'h00;
		{reg_addr, reg_wdata} = 16'h0000;
		rx_frame = '0;
		lag = 4'h3;
		seed = 32'h842402C3;
		{err_count, check_count, cycles} = {32'd0, 32'd0, 32'd0};
		nums = '{6'h00, 6'h23, 6'h05};
		tick(10);
		resetn = 1'b1;
		rd(ADDR_IRQ_ID_LOW);
		chk(64'(reg_rdata), 64'h00);
		rd(IFACE1_BASE + 8'h06);
		chk(64'(reg_rdata), 64'h20);
		rd(IFACE2_BASE + 8'h01);
		chk(64'(reg_rdata), 64'h00);
		rd(8'hF0);
		chk(64'(reg_rdata), 64'h00);
		foreach (nums[k]) begin
			seed = lfsr(seed);
			oid[fold(nums[k])] = seed[28:0];
			mk(seed[28:0], 3'b100, 8'h00);
			put(IFACE1_BASE, nums[k]);
			get(IFACE2_BASE, fold(nums[k]));
			for (int i = 0; i < 18; i++) chk(64'(q[i]), 64'(b[i]));
		end
		// two stores without the host clearing new data: first one is lost and the lost flag is set
		for (int j = 0; j < 2; j++) begin
			rx(oid[5], 1'b0, 1'b0, 1'b1);
			get(IFACE2_BASE, 6'h05);
			for (int i = 0; i < 8; i++) got[8 * i +: 8] = q[10 + i];
			chk(got, rx_frame.data);
			chk(64'(q[8]), 64'({4'h8, rx_frame.dlc}));
			chk(64'(q[9]), (j == 0) ? 64'hA0 : 64'hE0);
		end
		mk(oid[3], 3'b000, 8'h00);
		put(IFACE1_BASE, 6'h02);
		mk(oid[3], 3'b100, 8'h00);
		b[0] = 8'hFE;
		b[3] = 8'h3F;
		put(IFACE1_BASE, 6'h03);
		// extended frames, so the low identifier bits take part in the compare
		rx(oid[3] ^ 29'h2, 1'b1, 1'b0, 1'b0);
		rx(oid[3] ^ 29'h1, 1'b1, 1'b0, 1'b1);
		rd(IRQ_PENDING_ARRAY_ARR_BASE);
		chk(64'(reg_rdata), 64'h14);
		rd(NEW_DATA_ARRAY_ARRAY_BASE);
		chk(64'(reg_rdata), 64'h14);
		rd(VALID_ARR_BASE);
		chk(64'(reg_rdata), 64'h14);
		chk(64'(irq_source_identifier), 64'h0003);
		status_update = 1'b1;
		tick(1);
		status_update = 1'b0;
		tick(2);
		chk(64'(irq_source_identifier), 64'(STATUS_IRQ_ID));
		for (int i = 0; i < 4; i++) begin
			{irq_output_enable, irq_polarity_select} = 2'(i);
			tick(2);
			chk(64'(irq_output_pin), 64'(pin_exp(1'b1, irq_output_enable, irq_polarity_select)));
		end
		status_read = 1'b1;
		tick(1);
		status_read = 1'b0;
		tick(2);
		chk(64'(irq_source_identifier), 64'h0003);
		get(IFACE1_BASE, 6'h03);
		wr(IFACE1_BASE + 8'h0C, q[9] & 8'hDF);
		xfer(IFACE1_BASE, 6'h03, 1'b1);
		tick(2);
		chk(64'(irq_source_identifier), 64'h0005);
		wr(ADDR_IRQ_ID_LOW, 8'hFF);
		rd(ADDR_IRQ_ID_LOW);
		chk(64'(reg_rdata), 64'h05);
		lag = 4'h9;
		seed = lfsr(seed);
		// keep the identifier: building the image moves the seed on
		oid[7] = seed[28:0];
		mk(oid[7], 3'b101, 8'h10);
		put(IFACE1_BASE, 6'h07);
		rx(oid[7], 1'b0, 1'b1, 1'b1);
		chk(64'(tx_pending), 64'h1);
		tx_chk(i_core.n_sent, 5'h06, 1'b0);
		mk(seed[28:0] ^ 29'h4, 3'b100, 8'h01);
		put(IFACE1_BASE, 6'h09);
		tx_chk(i_core.n_sent, 5'h08, 1'b1);
		tick(3);
		chk(64'(tx_pending), 64'h0);
		wrap_up();
	end
endmodule : cmb_msg_buffer_tb_top
`default_nettype wire

/* inc/cmb_pkg.sv */
// message-buffer interface package: register map, field layout, object and frame carriers
// assumes one byte-wide register port from the serial host decoder, all on the module clock
package cmb_pkg;

	// sizes
	localparam int OBJ_COUNT = 32;
	localparam int NUM_IFACE = 2;

	// register map (byte addresses on the host register port)
	localparam logic [7:0] ADDR_IRQ_ID_LOW  = 8'h08;
	localparam logic [7:0] ADDR_IRQ_ID_HIGH = 8'h09;
	localparam logic [7:0] IFACE1_BASE      = 8'h10;
	localparam logic [7:0] IFACE2_BASE      = 8'h30;
	localparam logic [7:0] TRANSMIT_REQUEST_ARRAY_BASE  = 8'h80;
	localparam logic [7:0] NEW_DATA_ARRAY_ARRAY_BASE  = 8'h90;
	localparam logic [7:0] IRQ_PENDING_ARRAY_ARR_BASE  = 8'hA0;
	localparam logic [7:0] VALID_ARR_BASE   = 8'hB0;
	localparam logic [7:0] ARRAY_SPAN       = 8'h04;

	// offsets inside one interface set
	localparam logic [4:0] OFS_CREQ_LOW  = 5'h00;
	localparam logic [4:0] OFS_CREQ_HIGH = 5'h01;
	localparam logic [4:0] OFS_CMASK     = 5'h02;
	localparam logic [4:0] OFS_MASK_B0   = 5'h03;
	localparam logic [4:0] OFS_MASK_B1   = 5'h04;
	localparam logic [4:0] OFS_MASK_B2   = 5'h05;
	localparam logic [4:0] OFS_MASK_B3   = 5'h06;
	localparam logic [4:0] OFS_IDENT_B0  = 5'h07;
	localparam logic [4:0] OFS_IDENT_B1  = 5'h08;
	localparam logic [4:0] OFS_IDENT_B2  = 5'h09;
	localparam logic [4:0] OFS_IDENT_B3  = 5'h0A;
	localparam logic [4:0] OFS_MCTRL_LOW = 5'h0B;
	localparam logic [4:0] OFS_MCTRL_HI  = 5'h0C;
	localparam logic [4:0] OFS_DATA0     = 5'h0D;
	localparam logic [4:0] OFS_DATA7     = 5'h14;
	localparam logic [4:0] OFS_IF_SPAN   = 5'h1F;

	// bit positions
	localparam int CMASK_DIR_BIT = 7;
	localparam int BUSY_BIT      = 7;

	// reset values and fixed codes
	localparam logic [7:0]  CMASK_RESET    = 8'h00;
	localparam logic [5:0]  MSGNUM_RESET   = 6'h01;
	localparam logic [5:0]  MSGNUM_MAX     = 6'h20;
	localparam logic [15:0] STATUS_IRQ_ID  = 16'h8000;
	localparam logic [15:0] IRQ_ID_NONE    = 16'h0000;
	localparam logic [2:0]  XFER_CYCLES    = 3'h4;

	typedef struct packed {
		logic [28:0] mask;
		logic        mxtd;
		logic        mdir;
		logic [28:0] id;
		logic        xtd;
		logic        dir;
		logic        valid;
		logic        eob;
		logic        rmten;
		logic        transmit_request;
		logic        new_data_array;
		logic        lost;
		logic        irq_pending_array;
		logic [3:0]  dlc;
		logic [63:0] data;
	} cmb_obj_t;

	typedef struct packed {
		logic [28:0] id;
		logic        xtd;
		logic        remote;
		logic [3:0]  dlc;
		logic [63:0] data;
	} cmb_rx_frame_t;

	typedef struct packed {
		logic [4:0]  obj;
		logic [28:0] id;
		logic        xtd;
		logic        remote;
		logic [3:0]  dlc;
		logic [63:0] data;
	} cmb_tx_frame_t;

	typedef enum logic [1:0] {
		CMB_XS_IDLE = 2'b01,
		CMB_XS_BUSY = 2'b10
	} cmb_xfer_state_t;

endpackage : cmb_pkg

/* logic/cmb_msg_buffer.sv */
// message object store with two host interface buffer sets, acceptance, transmit pick
// and interrupt source identifier with level-selectable pin
// assumes the serial host decoder and the protocol core run on clk; no input needs syncing
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////////////////////
module cmb_msg_buffer
	import cmb_pkg::*;
(
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    resetn,
	// host register port
	input  wire logic [7:0]              reg_addr,
	input  wire logic [7:0]              reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic [7:0]                   reg_rdata,
	output logic                         host_wait_n,
	// protocol core: received frames
	input  wire logic                    rx_valid,
	input  wire cmb_pkg::cmb_rx_frame_t  rx_frame,
	output logic                         rx_hit,
	// protocol core: transmit
	output logic                         tx_pending,
	output cmb_pkg::cmb_tx_frame_t       tx_frame,
	input  wire logic                    tx_done,
	input  wire logic [4:0]              tx_done_obj,
	// protocol core: status register events
	input  wire logic                    status_update,
	input  wire logic                    status_read,
	// interrupt
	input  wire logic                    irq_output_enable,
	input  wire logic                    irq_polarity_select,
	output logic [15:0]                  irq_source_identifier,
	output logic                         irq_output_pin
);
	import cmb_pkg::*;

	//////////////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [5:0] fold_msgnum(input logic [5:0] n);
		if (n == 6'h00)
			fold_msgnum = MSGNUM_MAX;
		else if (n > MSGNUM_MAX)
			fold_msgnum = n - MSGNUM_MAX;
		else
			fold_msgnum = n;
	endfunction : fold_msgnum

	// lowest set bit wins; returns {found, index}
	function automatic logic [5:0] lowest_set(input logic [OBJ_COUNT-1:0] v);
		lowest_set = 6'h00;
		for (int i = OBJ_COUNT - 1; i >= 0; i--) begin
			if (v[i])
				lowest_set = {1'b1, 5'(i)};
		end
	endfunction : lowest_set

	function automatic cmb_obj_t buf_write(input cmb_obj_t b, input logic [4:0] ofs, input logic [7:0] d);
		buf_write = b;
		case (ofs)
			OFS_MASK_B0:   buf_write.mask[7:0] = d;
			OFS_MASK_B1:   buf_write.mask[15:8] = d;
			OFS_MASK_B2:   buf_write.mask[23:16] = d;
			OFS_MASK_B3:   {buf_write.mxtd, buf_write.mdir, buf_write.mask[28:24]} = {d[7:6], d[4:0]};
			OFS_IDENT_B0:  buf_write.id[7:0] = d;
			OFS_IDENT_B1:  buf_write.id[15:8] = d;
			OFS_IDENT_B2:  buf_write.id[23:16] = d;
			OFS_IDENT_B3:  {buf_write.valid, buf_write.xtd, buf_write.dir, buf_write.id[28:24]} = d;
			OFS_MCTRL_LOW: {buf_write.eob, buf_write.dlc} = {d[7], d[3:0]};
			OFS_MCTRL_HI:  {buf_write.new_data_array, buf_write.lost, buf_write.irq_pending_array, buf_write.rmten, buf_write.transmit_request} =
				{d[7:4], d[0]};
			default: begin
				if (ofs >= OFS_DATA0 && ofs <= OFS_DATA7)
					buf_write.data[8*(ofs-OFS_DATA0) +: 8] = d;
			end
		endcase
	endfunction : buf_write

	function automatic logic [7:0] buf_read(input cmb_obj_t b, input logic [4:0] ofs);
		case (ofs)
			OFS_MASK_B0:   buf_read = b.mask[7:0];
			OFS_MASK_B1:   buf_read = b.mask[15:8];
			OFS_MASK_B2:   buf_read = b.mask[23:16];
			OFS_MASK_B3:   buf_read = {b.mxtd, b.mdir, 1'b1, b.mask[28:24]};
			OFS_IDENT_B0:  buf_read = b.id[7:0];
			OFS_IDENT_B1:  buf_read = b.id[15:8];
			OFS_IDENT_B2:  buf_read = b.id[23:16];
			OFS_IDENT_B3:  buf_read = {b.valid, b.xtd, b.dir, b.id[28:24]};
			OFS_MCTRL_LOW: buf_read = {b.eob, 3'h0, b.dlc};
			OFS_MCTRL_HI:  buf_read = {b.new_data_array, b.lost, b.irq_pending_array, b.rmten, 3'h0, b.transmit_request};
			default: begin
				if (ofs >= OFS_DATA0 && ofs <= OFS_DATA7)
					buf_read = b.data[8*(ofs-OFS_DATA0) +: 8];
				else
					buf_read = 8'h00;
			end
		endcase
	endfunction : buf_read

	//////////////////////////////////////////////////////////////////////////////////////////
	// state

	cmb_obj_t        obj_reg   [OBJ_COUNT];
	cmb_obj_t        obj_next  [OBJ_COUNT];
	cmb_obj_t        buf_reg   [NUM_IFACE];
	cmb_obj_t        buf_next  [NUM_IFACE];
	cmb_xfer_state_t xs_reg    [NUM_IFACE];
	logic [2:0]      cnt_reg   [NUM_IFACE];
	logic [7:0]      cmask_reg [NUM_IFACE];
	logic [5:0]      msgnum_reg[NUM_IFACE];
	logic [NUM_IFACE-1:0] if_sel;
	logic [NUM_IFACE-1:0] if_busy;
	logic [NUM_IFACE-1:0] xfer_done;
	logic [NUM_IFACE-1:0] xfer_write;
	logic [4:0]      if_ofs    [NUM_IFACE];
	logic [4:0]      if_idx    [NUM_IFACE];
	logic [7:0]      if_rd     [NUM_IFACE];

	logic                 status_irq_reg;
	logic [15:0]          irq_id_next;
	logic [OBJ_COUNT-1:0] transmit_request_vec;
	logic [OBJ_COUNT-1:0] new_data_array_vec;
	logic [OBJ_COUNT-1:0] irq_pending_array_vec;
	logic [OBJ_COUNT-1:0] valid_vec;
	logic [OBJ_COUNT-1:0] rx_elig;
	logic [OBJ_COUNT-1:0] tx_cand;
	logic [5:0]           rx_pick;
	logic [5:0]           tx_pick;
	logic [5:0]           irq_pick;
	logic                 rx_take;
	logic [7:0]           rd_byte;
	logic [7:0]           arr_byte;
	logic [31:0]          arr_vec;
	logic                 arr_sel;
	cmb_tx_frame_t        tx_frame_next;

	//////////////////////////////////////////////////////////////////////////////////////////
	// interface register sets, built twice from one description

	generate
		for (genvar s = 0; s < NUM_IFACE; s++) begin : g_iface
			localparam logic [7:0] BASE = (s == 0) ? IFACE1_BASE : IFACE2_BASE;
			logic [7:0] rel;

			assign rel           = reg_addr - BASE;
			assign if_sel[s]     = (reg_addr >= BASE) && (rel <= {3'h0, OFS_IF_SPAN});
			assign if_ofs[s]     = rel[4:0];
			assign if_busy[s]    = (xs_reg[s] == CMB_XS_BUSY);
			assign if_idx[s]     = 5'(msgnum_reg[s] - 6'h01);
			assign xfer_done[s]  = if_busy[s] && (cnt_reg[s] == XFER_CYCLES - 3'h1);
			assign xfer_write[s] = cmask_reg[s][CMASK_DIR_BIT];
			assign if_rd[s]      = (if_ofs[s] == OFS_CREQ_LOW)  ? {2'h0, msgnum_reg[s]} :
			                       (if_ofs[s] == OFS_CREQ_HIGH) ? {if_busy[s], 7'h00} :
			                       (if_ofs[s] == OFS_CMASK)     ? cmask_reg[s] :
			                       buf_read(buf_reg[s], if_ofs[s]);

			// host writes to the buffer are ignored while its own transfer runs; a read transfer loads it in its last cycle
			always_comb begin
				buf_next[s] = buf_reg[s];
				if (reg_wr && if_sel[s] && !if_busy[s])
					buf_next[s] = buf_write(buf_reg[s], if_ofs[s], reg_wdata);
				if (xfer_done[s] && !xfer_write[s])
					buf_next[s] = obj_reg[if_idx[s]];
			end

			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					buf_reg[s]    <= '0;
					xs_reg[s]     <= CMB_XS_IDLE;
					cnt_reg[s]    <= 3'h0;
					cmask_reg[s]  <= CMASK_RESET;
					msgnum_reg[s] <= MSGNUM_RESET;
				end else begin
					buf_reg[s] <= buf_next[s];
					case (xs_reg[s])
						CMB_XS_IDLE: begin
							cnt_reg[s] <= 3'h0;
							if (reg_wr && if_sel[s] && if_ofs[s] == OFS_CMASK)
								cmask_reg[s] <= reg_wdata;
							if (reg_wr && if_sel[s] && if_ofs[s] == OFS_CREQ_LOW) begin
								msgnum_reg[s] <= fold_msgnum(reg_wdata[5:0]);
								xs_reg[s]     <= CMB_XS_BUSY;
							end
						end
						CMB_XS_BUSY: begin
							cnt_reg[s] <= cnt_reg[s] + 3'h1;
							if (xfer_done[s])
								xs_reg[s] <= CMB_XS_IDLE;
						end
						default: xs_reg[s] <= CMB_XS_IDLE;
					endcase
				end
			end
		end
	endgenerate

	assign host_wait_n = ~(|if_busy);

	//////////////////////////////////////////////////////////////////////////////////////////
	// acceptance filtering and message object store

	generate
		for (genvar k = 0; k < OBJ_COUNT; k++) begin : g_obj
			cmb_obj_t    o;
			logic [28:0] id_diff;
			logic        id_ok;
			logic        fmt_ok;
			logic        dir_ok;

			assign o         = obj_reg[k];
			assign id_diff   = (o.id ^ rx_frame.id) & o.mask;
			// a standard frame only carries identifier bits 28..18
			assign id_ok     = rx_frame.xtd ? (id_diff == 29'h0) : (id_diff[28:18] == 11'h000);
			assign fmt_ok    = !o.mxtd || (o.xtd == rx_frame.xtd);
			assign dir_ok    = !o.mdir || (o.dir == rx_frame.remote);
			assign rx_elig[k] = o.valid && id_ok && fmt_ok && dir_ok &&
			                    (o.dir == rx_frame.remote);
			assign tx_cand[k]    = o.valid && o.transmit_request;
			assign transmit_request_vec[k]   = o.transmit_request;
			assign new_data_array_vec[k]   = o.new_data_array;
			assign irq_pending_array_vec[k] = o.irq_pending_array;
			assign valid_vec[k]  = o.valid;

			// host transfers first, handler events after, so a handler set is never lost to a host transfer
			always_comb begin
				obj_next[k] = obj_reg[k];
				for (int s = NUM_IFACE - 1; s >= 0; s--) begin
					if (xfer_done[s] && xfer_write[s] && if_idx[s] == 5'(k))
						obj_next[k] = buf_reg[s];
				end
				if (rx_take && rx_pick[4:0] == 5'(k)) begin
					if (rx_frame.remote) begin
						if (obj_next[k].rmten)
							obj_next[k].transmit_request = 1'b1;
					end else begin
						obj_next[k].lost   = obj_next[k].lost | obj_next[k].new_data_array;
						obj_next[k].new_data_array   = 1'b1;
						obj_next[k].dlc    = rx_frame.dlc;
						obj_next[k].data   = rx_frame.data;
						obj_next[k].irq_pending_array = 1'b1;
					end
				end
				if (tx_done && tx_done_obj == 5'(k)) begin
					obj_next[k].transmit_request   = 1'b0;
					obj_next[k].irq_pending_array = 1'b1;
				end
			end

			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn)
					obj_reg[k] <= '0;
				else
					obj_reg[k] <= obj_next[k];
			end
		end
	endgenerate

	assign rx_pick  = lowest_set(rx_elig);
	assign rx_take  = rx_valid && rx_pick[5];
	assign tx_pick  = lowest_set(tx_cand);
	assign irq_pick = lowest_set(irq_pending_array_vec);

	//////////////////////////////////////////////////////////////////////////////////////////
	// transmit selection: lowest object number goes first

	always_comb begin
		tx_frame_next        = '0;
		tx_frame_next.obj    = tx_pick[4:0];
		tx_frame_next.id     = obj_reg[tx_pick[4:0]].id;
		tx_frame_next.xtd    = obj_reg[tx_pick[4:0]].xtd;
		tx_frame_next.remote = ~obj_reg[tx_pick[4:0]].dir;
		tx_frame_next.dlc    = obj_reg[tx_pick[4:0]].dlc;
		tx_frame_next.data   = obj_reg[tx_pick[4:0]].data;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_pending <= 1'b0;
			tx_frame   <= '0;
			rx_hit     <= 1'b0;
		end else begin
			tx_pending <= tx_pick[5];
			tx_frame   <= tx_frame_next;
			rx_hit     <= rx_take;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// interrupt identifier and pin

	// status writes by the host never reach this block, so they cannot touch the flag
	assign irq_id_next = status_irq_reg ? STATUS_IRQ_ID :
	                     irq_pick[5]    ? {10'h000, 6'(irq_pick[4:0]) + 6'h01} :
	                     IRQ_ID_NONE;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status_irq_reg        <= 1'b0;
			irq_source_identifier <= IRQ_ID_NONE;
			irq_output_pin        <= 1'b0;
		end else begin
			// a new update in the read cycle keeps the flag set
			if (status_update)
				status_irq_reg <= 1'b1;
			else if (status_read)
				status_irq_reg <= 1'b0;
			irq_source_identifier <= irq_id_next;
			irq_output_pin <= ((irq_source_identifier != IRQ_ID_NONE) && irq_output_enable) ?
				irq_polarity_select : ~irq_polarity_select;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// host read path; no host address writes the arrays or identifier; array bits change through buffer transfers

	assign arr_sel  = (reg_addr[7:2] == TRANSMIT_REQUEST_ARRAY_BASE[7:2]) || (reg_addr[7:2] == NEW_DATA_ARRAY_ARRAY_BASE[7:2]) ||
	                  (reg_addr[7:2] == IRQ_PENDING_ARRAY_ARR_BASE[7:2]) || (reg_addr[7:2] == VALID_ARR_BASE[7:2]);
	assign arr_vec  = (reg_addr[7:2] == TRANSMIT_REQUEST_ARRAY_BASE[7:2]) ? transmit_request_vec :
	                  (reg_addr[7:2] == NEW_DATA_ARRAY_ARRAY_BASE[7:2]) ? new_data_array_vec :
	                  (reg_addr[7:2] == IRQ_PENDING_ARRAY_ARR_BASE[7:2]) ? irq_pending_array_vec : valid_vec;
	assign arr_byte = arr_vec[8*reg_addr[1:0] +: 8];
	assign rd_byte  = (reg_addr == ADDR_IRQ_ID_LOW)  ? irq_source_identifier[7:0] :
	                  (reg_addr == ADDR_IRQ_ID_HIGH) ? irq_source_identifier[15:8] :
	                  if_sel[0] ? if_rd[0] :
	                  if_sel[1] ? if_rd[1] :
	                  arr_sel   ? arr_byte : 8'h00;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rd_byte;
	end

endmodule : cmb_msg_buffer

`default_nettype wire
